//--- hw/gpio_port_pkg.sv
// Shared constants, carriers and helpers for the three-port pin block.
// Assumes word-aligned AHB-Lite access, one 8-bit register per word.
package gpio_port_pkg;

    // Port geometry
    localparam int PORT_COUNT = 3;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_ZERO_DATA = 8'h18;
    localparam logic [7:0] IDX_ONE_DATA = 8'h19;
    localparam logic [7:0] IDX_TWO_DATA = 8'h1A;
    localparam logic [7:0] IDX_ZERO_DIR = 8'h20;
    localparam logic [7:0] IDX_ONE_DIR = 8'h21;
    localparam logic [7:0] IDX_TWO_DIR = 8'h22;
    localparam logic [7:0] IDX_ZERO_SEL = 8'h28;
    localparam logic [7:0] IDX_ONE_SEL = 8'h29;
    localparam logic [7:0] IDX_TWO_SEL = 8'h2A;
    localparam int IDX_LSB = 2;

    // Register kinds within a port
    localparam logic [1:0] KIND_DATA = 2'h0;
    localparam logic [1:0] KIND_DIR = 2'h1;
    localparam logic [1:0] KIND_SEL = 2'h2;

    // Reset values
    localparam logic [7:0] CFG_CLEAR = 8'h00;
    localparam logic [7:0] EXT_WIDE_CFG = 8'hFF;
    localparam logic [7:0] EXT_NARROW_CFG = 8'h0F;

    // Implemented bits, bits with an alternate function and access-pin-low reset images, port 2 in the top byte
    localparam logic [23:0] BIT_MASKS = 24'h0F_FFFF;
    localparam logic [23:0] ALT_MASKS = 24'h0F_FFFF;
    localparam logic [23:0] EXT_CFGS = 24'h0F_FFFF;

    // Bus response
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [23:0] RDATA_PAD = 24'h00_0000;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] sel;
    } port_regs_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pad_t;

    typedef struct packed {
        logic mux_mode;
        logic addr_phase;
        logic data_drive;
        logic [19:0] addr;
        logic [7:0] wdata;
    } ext_bus_t;

    typedef struct packed {
        logic hit;
        logic [1:0] port;
        logic [1:0] kind;
    } reg_sel_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ_WAIT = 2'b10,
        BUS_READ_DONE = 2'b11
    } bus_state_t;

    // Per-bit read path: pin, latch or alternate output
    function automatic logic [7:0] read_select(input logic [7:0] dir, input logic [7:0] sel,
                                               input logic [7:0] pin, input logic [7:0] latch,
                                               input logic [7:0] alt);
        read_select = (~dir & pin) | (dir & ~sel & latch) | (dir & sel & alt);
    endfunction : read_select

endpackage : gpio_port_pkg

//--- hw/port_pad_mux.sv
// Pin-side mux for one port: drive, enable, pull-up and read value.
// Assumes registered configuration in; all paths here are combinational.
`timescale 1ns/10ps
`default_nettype none

module port_pad_mux
    import gpio_port_pkg::*;
#(
    parameter logic [7:0] BIT_MASK = 8'hFF,
    parameter logic [7:0] ALT_MASK = 8'hFF
) (
    input wire port_regs_t regs,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    input wire logic [7:0] pin_in,
    output pad_t pad,
    output logic [7:0] read_value
);

    logic [7:0] alt_sel;
    logic [7:0] alt_val;

    // Bits without an alternate function put out zero when it is selected
    assign alt_sel = regs.dir & regs.sel;
    assign alt_val = alt_out & ALT_MASK;

    // Latch drive when direction is out, alternate only when both bits set
    assign pad.out = ((alt_sel & alt_val) | (~alt_sel & regs.data)) & BIT_MASK;
    assign pad.oe = ((regs.dir & ~regs.sel) | (alt_sel & (alt_oe | ~ALT_MASK))) & BIT_MASK;
    // Pull-up only on input bits with the select set
    assign pad.pull = ~regs.dir & regs.sel & BIT_MASK;

    // Missing bits read as zero
    assign read_value = read_select(regs.dir, regs.sel, pin_in, regs.data, alt_val)
                        & BIT_MASK;

endmodule : port_pad_mux

`default_nettype wire

//--- hw/bidir_port_with_alt_function.sv
// Three bidirectional ports (8, 8 and 4 bits) with alternate bus functions,
// configured over an AHB-Lite slave port.
// Assumes pin inputs synchronous to sys_clk and a single AHB master.
//
// Behaviour
// - Alternate select on a bit lacking an alternate function drives zero.
// - Data read gives pin, latch, or alternate output per direction and select.
// - Each bit's direction is separate; output direction drives the latch bit.
// - Alternate output reaches the pin only with direction and select both one.
// - Input direction with select one enables the pin pull-up.
// - Any reset with access pin high clears all data, direction, select registers.
// - Access pin low at reset: port zero direction and select load all ones.
// - Access pin low at reset: port one direction and select load all ones.
// - Access pin low at reset: port two direction and select load 0F.
// - Port zero alternate carries memory data, plus address in multiplexed mode.
// - Port one alternate function outputs external memory address bits.
// - Port two has four bits; upper register bits read zero.
// - Unimplemented register bits always read as zero.
// - Read-modify-write reads the selected path and writes result to latch.
// - Data writes update every latch bit regardless of direction.
// - Alternate inputs come from the pin regardless of select.
`timescale 1ns/10ps
`default_nettype none

module bidir_port_with_alt_function
    import gpio_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic break_instruction,
    input wire logic watchdog_overflow,
    input wire logic opcode_trap,
    input wire logic external_access_pin_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ext_bus_t ext_bus,
    output logic [7:0] ext_read_data,
    input wire logic [7:0] port_zero_pin_in,
    input wire logic [7:0] port_one_pin_in,
    input wire logic [3:0] port_two_pin_in,
    output pad_t port_zero_pad,
    output pad_t port_one_pad,
    output pad_t port_two_pad
);

    port_regs_t regs_reg [PORT_COUNT];
    pad_t pads [PORT_COUNT];
    logic [7:0] pins [PORT_COUNT];
    logic [7:0] alt_outs [PORT_COUNT];
    logic [7:0] alt_oes [PORT_COUNT];
    logic [7:0] read_values [PORT_COUNT];
    bus_state_t state_reg;
    bus_state_t state_next;
    reg_sel_t sel_reg;
    reg_sel_t addr_sel;
    logic [DATA_W-1:0] hrdata_reg;
    logic [7:0] ext_read_data_reg;
    logic [7:0] read_byte;
    logic rst_req;
    logic accept;
    logic [2:0] unused_size;

    // Register index decode; anything else is unmapped
    function automatic reg_sel_t decode(input logic [7:0] idx);
        reg_sel_t r;
        r = '0;
        r.hit = 1'b1;
        if (idx == IDX_ZERO_DATA) begin
            r.port = 2'd0;
            r.kind = KIND_DATA;
        end else if (idx == IDX_ONE_DATA) begin
            r.port = 2'd1;
            r.kind = KIND_DATA;
        end else if (idx == IDX_TWO_DATA) begin
            r.port = 2'd2;
            r.kind = KIND_DATA;
        end else if (idx == IDX_ZERO_DIR) begin
            r.port = 2'd0;
            r.kind = KIND_DIR;
        end else if (idx == IDX_ONE_DIR) begin
            r.port = 2'd1;
            r.kind = KIND_DIR;
        end else if (idx == IDX_TWO_DIR) begin
            r.port = 2'd2;
            r.kind = KIND_DIR;
        end else if (idx == IDX_ZERO_SEL) begin
            r.port = 2'd0;
            r.kind = KIND_SEL;
        end else if (idx == IDX_ONE_SEL) begin
            r.port = 2'd1;
            r.kind = KIND_SEL;
        end else if (idx == IDX_TWO_SEL) begin
            r.port = 2'd2;
            r.kind = KIND_SEL;
        end else begin
            r.hit = 1'b0;
        end
        return r;
    endfunction : decode

    // Every reset source acts alike; all are sampled on the clock
    assign rst_req = !reset_n || break_instruction || watchdog_overflow || opcode_trap;
    assign accept = hsel && htrans[1] && hready;
    assign addr_sel = decode(haddr[IDX_LSB+7:IDX_LSB]);
    assign unused_size = hsize; // Only whole-word transfers; byte lanes not used

    // Alternate sources: port zero muxes address and data, ports one and two address
    always_comb begin
        if (ext_bus.mux_mode && ext_bus.addr_phase) begin
            alt_outs[0] = ext_bus.addr[7:0];
        end else begin
            alt_outs[0] = ext_bus.wdata;
        end
        alt_oes[0] = {8{(ext_bus.mux_mode && ext_bus.addr_phase) || ext_bus.data_drive}};
        alt_outs[1] = ext_bus.addr[15:8];
        alt_oes[1] = 8'hFF;
        alt_outs[2] = {4'h0, ext_bus.addr[19:16]};
        alt_oes[2] = 8'hFF;
    end

    assign pins[0] = port_zero_pin_in;
    assign pins[1] = port_one_pin_in;
    assign pins[2] = {4'h0, port_two_pin_in};

    // One pin mux per port
    for (genvar gi = 0; gi < PORT_COUNT; gi++) begin : g_port
        port_pad_mux #(
            .BIT_MASK(BIT_MASKS[gi*8 +: 8]),
            .ALT_MASK(ALT_MASKS[gi*8 +: 8])
        ) u_mux (
            .regs(regs_reg[gi]),
            .alt_out(alt_outs[gi]),
            .alt_oe(alt_oes[gi]),
            .pin_in(pins[gi]),
            .pad(pads[gi]),
            .read_value(read_values[gi])
        );
    end

    assign port_zero_pad = pads[0];
    assign port_one_pad = pads[1];
    assign port_two_pad = pads[2];

    // Bus sequencer: reads take one wait state so a preceding write has landed
    always_comb begin
        case (state_reg)
            BUS_READ_WAIT: state_next = BUS_READ_DONE;
            default: begin
                if (accept && hwrite) begin
                    state_next = BUS_WRITE;
                end else if (accept) begin
                    state_next = BUS_READ_WAIT;
                end else begin
                    state_next = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst_req) begin
            state_reg <= BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Address phase capture
    always_ff @(posedge sys_clk) begin
        if (rst_req) begin
            sel_reg <= '0;
        end else if (accept && state_reg != BUS_READ_WAIT) begin
            sel_reg <= addr_sel;
        end
    end

    // Configuration and latches; the access pin picks the reset image
    always_ff @(posedge sys_clk) begin
        if (rst_req) begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                regs_reg[i].data <= CFG_CLEAR;
                if (external_access_pin_n) begin
                    regs_reg[i].dir <= CFG_CLEAR;
                    regs_reg[i].sel <= CFG_CLEAR;
                end else begin
                    regs_reg[i].dir <= EXT_CFGS[i*8 +: 8];
                    regs_reg[i].sel <= EXT_CFGS[i*8 +: 8];
                end
            end
        end else if (state_reg == BUS_WRITE && sel_reg.hit) begin
            // Writes land whatever the direction; masked so missing bits stay zero
            case (sel_reg.kind)
                KIND_DATA: regs_reg[sel_reg.port].data <=
                    hwdata[7:0] & BIT_MASKS[sel_reg.port*8 +: 8];
                KIND_DIR: regs_reg[sel_reg.port].dir <=
                    hwdata[7:0] & BIT_MASKS[sel_reg.port*8 +: 8];
                default: regs_reg[sel_reg.port].sel <=
                    hwdata[7:0] & BIT_MASKS[sel_reg.port*8 +: 8];
            endcase
        end
    end

    // Read byte: data goes through the pin/latch/alternate path
    always_comb begin
        read_byte = 8'h00;
        if (sel_reg.hit) begin
            case (sel_reg.kind)
                KIND_DATA: read_byte = read_values[sel_reg.port];
                KIND_DIR: read_byte = regs_reg[sel_reg.port].dir;
                default: read_byte = regs_reg[sel_reg.port].sel;
            endcase
        end
    end

    // Read data registered in the wait cycle; upper bits and unmapped read zero
    always_ff @(posedge sys_clk) begin
        if (rst_req) begin
            hrdata_reg <= '0;
        end else if (state_reg == BUS_READ_WAIT) begin
            hrdata_reg <= {RDATA_PAD, read_byte};
        end
    end

    // Memory read data comes straight from the port zero pins
    always_ff @(posedge sys_clk) begin
        if (rst_req) begin
            ext_read_data_reg <= 8'h00;
        end else begin
            ext_read_data_reg <= port_zero_pin_in;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = (state_reg != BUS_READ_WAIT);
    assign hresp = HRESP_OKAY;
    assign ext_read_data = ext_read_data_reg;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst_req);

    sequence s_read_start;
        accept && !hwrite && hreadyout;
    endsequence

    sequence s_write_zero_data;
        accept && hwrite && hreadyout && addr_sel.hit && addr_sel.port == 2'd0
            && addr_sel.kind == KIND_DATA;
    endsequence

    chk_reset_internal: assert property (disable iff (1'b0)
        rst_req && external_access_pin_n |=> regs_reg[0] == '0 && regs_reg[1] == '0
            && regs_reg[2] == '0 && port_zero_pad.oe == 8'h00)
        else $error("internal reset image wrong");

    chk_reset_data_port: assert property (disable iff (1'b0)
        rst_req && !external_access_pin_n |=> regs_reg[0].dir == EXT_WIDE_CFG
            && regs_reg[0].sel == EXT_WIDE_CFG && regs_reg[0].data == CFG_CLEAR)
        else $error("port zero external reset image wrong");

    chk_reset_addr_port: assert property (disable iff (1'b0)
        rst_req && !external_access_pin_n |=> regs_reg[1].dir == EXT_WIDE_CFG
            && regs_reg[1].sel == EXT_WIDE_CFG && regs_reg[1].data == CFG_CLEAR)
        else $error("port one external reset image wrong");

    chk_reset_narrow_port: assert property (disable iff (1'b0)
        rst_req && !external_access_pin_n |=> regs_reg[2].dir == EXT_NARROW_CFG
            && regs_reg[2].sel == EXT_NARROW_CFG && regs_reg[2].data == CFG_CLEAR)
        else $error("port two external reset image wrong");

    chk_latch_drive: assert property (
        ((port_one_pad.oe & regs_reg[1].dir & ~regs_reg[1].sel)
            == (regs_reg[1].dir & ~regs_reg[1].sel))
        && (((port_one_pad.out ^ regs_reg[1].data) & regs_reg[1].dir & ~regs_reg[1].sel)
            == 8'h00))
        else $error("latch not driven on output bits");

    chk_alt_route: assert property (
        ((port_one_pad.out ^ ext_bus.addr[15:8]) & regs_reg[1].dir & regs_reg[1].sel) == 8'h00
        && ((port_one_pad.out ^ regs_reg[1].data) & ~(regs_reg[1].dir & regs_reg[1].sel))
            == 8'h00)
        else $error("alternate output routed wrongly");

    chk_pull_enable: assert property (
        port_zero_pad.pull == (~regs_reg[0].dir & regs_reg[0].sel)
        && port_zero_pad.oe == ((regs_reg[0].dir & ~regs_reg[0].sel)
            | (regs_reg[0].dir & regs_reg[0].sel & alt_oes[0])))
        else $error("pull-up or enable mismatch");

    chk_read_path: assert property (
        s_read_start ##1 (sel_reg.hit && sel_reg.kind == KIND_DATA && sel_reg.port == 2'd1)
        |=> hrdata[7:0] == read_select($past(regs_reg[1].dir), $past(regs_reg[1].sel),
            $past(port_one_pin_in), $past(regs_reg[1].data), $past(ext_bus.addr[15:8])))
        else $error("port one read value wrong");

    chk_narrow_zero: assert property (
        regs_reg[2].data[7:4] == 4'h0 && regs_reg[2].dir[7:4] == 4'h0
            && regs_reg[2].sel[7:4] == 4'h0 && port_two_pad.oe[7:4] == 4'h0)
        else $error("port two upper bits set");

    chk_read_upper_zero: assert property (
        state_reg == BUS_READ_DONE |-> hrdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");

    chk_write_latch: assert property (
        s_write_zero_data ##1 state_reg == BUS_WRITE
        |=> regs_reg[0].data == $past(hwdata[7:0]))
        else $error("data write did not land");

    chk_read_timing: assert property (
        s_read_start |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    chk_alt_input: assert property (
        !rst_req |=> ext_read_data == $past(port_zero_pin_in))
        else $error("alternate input not from pin");

    chk_rmw_input_bits: assert property (
        s_read_start ##1 (sel_reg.hit && sel_reg.kind == KIND_DATA && sel_reg.port == 2'd0)
        |=> ((hrdata[7:0] ^ $past(port_zero_pin_in)) & ~$past(regs_reg[0].dir)) == 8'h00)
        else $error("input bits did not read pin level");

endmodule : bidir_port_with_alt_function

`default_nettype wire

//--- test/pin_partner.sv
// Far-side model of one port: the board source and pull-ups on the pins.
// Assumes pads change just after sys_clk edges; an undriven unpulled pin toggles.
`timescale 1ns/10ps
`default_nettype none

module pin_partner
    import gpio_port_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire pad_t pad,
    input wire logic [W-1:0] drive_val,
    input wire logic float_en,
    output logic [W-1:0] pin_in
);
    logic [W-1:0] last_reg = '0;

    // Wire level: device drive wins, then the board source, then the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad.oe[i]) begin
                pin_in[i] = pad.out[i];
            end else if (!float_en) begin
                pin_in[i] = drive_val[i];
            end else if (pad.pull[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ~last_reg[i]; // A floating line must never look stable
            end
        end
    end

    // Last level, so a released line can show its inverse
    always_ff @(posedge sys_clk) begin
        last_reg <= pin_in;
    end
endmodule : pin_partner

`default_nettype wire

//--- test/bidir_port_with_alt_function_tb.sv
// Self-checking bench for the three-port pin block with a bit-level model.
// Assumes pin partners on every port; ext_bus is random stimulus.
`timescale 1ns/10ps
`default_nettype none

module bidir_port_with_alt_function_tb
    import gpio_port_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n, break_instruction, watchdog_overflow, opcode_trap;
    logic external_access_pin_n, hsel, hwrite, hreadyout, hresp, float_en;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [DATA_W-1:0] hwdata, hrdata;
    ext_bus_t ext_bus;
    logic [7:0] ext_read_data, pin0, pin1;
    logic [3:0] pin2;
    logic [7:0] drv [3];
    pad_t pad [3];
    logic [7:0] m_data [3], m_dir [3], m_sel [3];
    logic [31:0] lfsr_reg = 32'h0000_0051;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    bidir_port_with_alt_function dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .break_instruction(break_instruction),
        .watchdog_overflow(watchdog_overflow), .opcode_trap(opcode_trap),
        .external_access_pin_n(external_access_pin_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_bus(ext_bus), .ext_read_data(ext_read_data), .port_zero_pin_in(pin0),
        .port_one_pin_in(pin1), .port_two_pin_in(pin2), .port_zero_pad(pad[0]),
        .port_one_pad(pad[1]), .port_two_pad(pad[2])
    );
    pin_partner #(.W(8)) far0 (.sys_clk(sys_clk), .pad(pad[0]), .drive_val(drv[0]),
        .float_en(float_en), .pin_in(pin0));
    pin_partner #(.W(8)) far1 (.sys_clk(sys_clk), .pad(pad[1]), .drive_val(drv[1]),
        .float_en(float_en), .pin_in(pin1));
    pin_partner #(.W(4)) far2 (.sys_clk(sys_clk), .pad(pad[2]), .drive_val(drv[2][3:0]),
        .float_en(float_en), .pin_in(pin2));

    // 10 MHz clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // Hang guard: the whole run needs under two thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr_reg = lfsr_reg[0] ? (lfsr_reg >> 1) ^ 32'hA300_0000 : lfsr_reg >> 1;
        return lfsr_reg;
    endfunction : rnd

    function automatic logic [7:0] msk(input int p);
        return (p == 2) ? 8'h0F : 8'hFF;
    endfunction : msk

    function automatic logic [31:0] addr_of(input int p, input int k);
        return {22'h00_0000, IDX_ZERO_DATA + 8'(k * 8 + p), 2'b00};
    endfunction : addr_of

    // Alternate output value and its enable, per port
    function automatic logic [7:0] alt(input int p);
        case (p)
            0: return (ext_bus.mux_mode && ext_bus.addr_phase) ? ext_bus.addr[7:0]
                                                               : ext_bus.wdata;
            1: return ext_bus.addr[15:8];
            default: return {4'h0, ext_bus.addr[19:16]};
        endcase
    endfunction : alt

    function automatic logic aoe(input int p);
        return (p != 0) || (ext_bus.mux_mode && ext_bus.addr_phase) || ext_bus.data_drive;
    endfunction : aoe

    // Expected register read; data reads pick pin, latch or alternate per bit
    function automatic logic [7:0] exp_reg(input int p, input int k);
        logic [7:0] lvl;
        lvl = float_en ? 8'hFF : drv[p];
        case (k)
            0: return msk(p) & ((~m_dir[p] & lvl) | (m_dir[p] & ~m_sel[p] & m_data[p])
                                | (m_dir[p] & m_sel[p] & alt(p)));
            1: return m_dir[p];
            default: return m_sel[p];
        endcase
    endfunction : exp_reg

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One AHB-Lite single transfer; every change right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input int p, input int k, input logic [7:0] v);
        logic [31:0] r;
        logic [31:0] dummy;
        r = rnd();
        bus(1'b1, addr_of(p, k), {r[31:8], v}, dummy);
        case (k)
            0: m_data[p] = v & msk(p);
            1: m_dir[p] = v & msk(p);
            default: m_sel[p] = v & msk(p);
        endcase
    endtask : wr

    task automatic rd(input int p, input int k, output logic [7:0] v);
        logic [31:0] got;
        logic [7:0] e;
        e = exp_reg(p, k);
        bus(1'b0, addr_of(p, k), 32'h0000_0000, got);
        chk($sformatf("reg %0d.%0d", p, k), {24'h00_0000, e}, got);
        chk("resp", {31'h0000_0000, HRESP_OKAY}, {31'h0000_0000, hresp});
        v = got[7:0];
    endtask : rd

    // Pads seen mid-cycle; out only compared where the device drives
    task automatic chk_pad(input int p);
        logic [7:0] oe;
        logic [7:0] out;
        @(negedge sys_clk);
        oe = m_dir[p] & (~m_sel[p] | {8{aoe(p)}});
        out = (m_sel[p] & alt(p)) | (~m_sel[p] & m_data[p]);
        chk($sformatf("pads %0d", p), {8'h00, out & oe, oe, ~m_dir[p] & m_sel[p]},
            {8'h00, pad[p].out & oe, pad[p].oe, pad[p].pull});
    endtask : chk_pad

    task automatic model_reset(input logic ea);
        for (int q = 0; q < 3; q++) begin
            m_data[q] = 8'h00;
            m_dir[q] = ea ? 8'h00 : msk(q);
            m_sel[q] = ea ? 8'h00 : msk(q);
        end
    endtask : model_reset

    // Source 0 is the reset pin, 1..3 the break, watchdog and trap requests
    task automatic do_reset(input int src, input logic ea);
        @(posedge sys_clk);
        external_access_pin_n <= ea;
        reset_n <= (src != 0);
        break_instruction <= (src == 1);
        watchdog_overflow <= (src == 2);
        opcode_trap <= (src == 3);
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        break_instruction <= 1'b0;
        watchdog_overflow <= 1'b0;
        opcode_trap <= 1'b0;
        model_reset(ea);
    endtask : do_reset

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial begin
        logic [7:0] v;
        logic [31:0] r;
        int p;
        reset_n = 1'b0;
        {break_instruction, watchdog_overflow, opcode_trap, hsel, hwrite} = '0;
        external_access_pin_n = 1'b1;
        haddr = '0;
        htrans = 2'b00;
        hwdata = '0;
        ext_bus = '0;
        float_en = 1'b0;
        drv = '{8'h00, 8'h00, 8'h00};
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        model_reset(1'b1);
        // Reset image, then an unmapped word
        for (int q = 0; q < 3; q++) begin
            for (int k = 0; k < 3; k++) begin
                rd(q, k, v);
            end
            chk_pad(q);
        end
        bus(1'b1, 32'h0000_006C, 32'hFFFF_FFFF, r);
        bus(1'b0, 32'h0000_006C, 32'h0000_0000, r);
        chk("unmapped", 32'h0000_0000, r);
        // Random configurations against pads and read paths
        repeat (40) begin
            p = rnd() % 3;
            r = rnd();
            drv[p] <= r[7:0];
            r = rnd();
            ext_bus <= r[30:0];
            r = rnd();
            wr(p, 1, r[7:0]);
            wr(p, 2, r[15:8]);
            wr(p, 0, r[23:16]);
            chk_pad(p);
            v = pin0; // Settled level that the next edge copies
            @(negedge sys_clk);
            chk("echo", {24'h00_0000, v}, {24'h00_0000, ext_read_data});
            rd(p, 0, v);
            rd(p, 1, v);
            rd(p, 2, v);
        end
        // Latch writes on input bits, then a read-modify-write
        for (int q = 0; q < 3; q++) begin
            r = rnd();
            drv[q] <= r[7:0];
            wr(q, 2, 8'h00);
            wr(q, 1, 8'h00);
            wr(q, 0, r[15:8]);
            wr(q, 1, 8'hFF);
            rd(q, 0, v);
            wr(q, 1, 8'h00);
            rd(q, 0, v);
            wr(q, 0, v ^ 8'h5A);
            wr(q, 1, 8'hFF);
            rd(q, 0, v);
        end
        // Board lets go: pulled-up inputs must read high
        float_en <= 1'b1;
        for (int q = 0; q < 3; q++) begin
            wr(q, 1, 8'h00);
            wr(q, 2, 8'hFF);
            chk_pad(q);
            rd(q, 0, v);
        end
        float_en <= 1'b0;
        // Every reset source with the access pin both ways
        for (int s = 0; s < 4; s++) begin
            for (int e = 0; e < 2; e++) begin
                do_reset(s, e[0]);
                for (int q = 0; q < 3; q++) begin
                    rd(q, 1, v);
                    rd(q, 2, v);
                    rd(q, 0, v);
                    chk_pad(q);
                end
            end
        end
        give_verdict();
    end
endmodule : bidir_port_with_alt_function_tb

`default_nettype wire
